// File: design/prio_pkg.sv
package prio_pkg;

  // Special function register address of the extended priority register
  localparam logic [7:0] EIP_ONE_ADDR = 8'hf6;
  localparam logic [7:0] EIP_ONE_RESET = 8'h00;

  // Field positions inside the register
  localparam int TIMER3_BIT = 7;
  localparam int COMP_B_BIT = 6;
  localparam int COMP_A_BIT = 5;
  localparam int COUNTER_ARRAY_BIT = 4;
  localparam int CONVERSION_DONE_BIT = 3;

  // Register access from the core; read and write strobes can share a cycle
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_t;

  // Per-source priority levels handed to the arbiter, 1 = high
  typedef struct packed {
    logic timer3;
    logic comparator_b;
    logic comparator_a;
    logic counter_array;
    logic conversion_done;
  } prio_sel_t;

endpackage : prio_pkg

// File: design/ext_interrupt_priority_reg.sv
`timescale 1ns/1ns
module ext_interrupt_priority_reg #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input prio_pkg::sfr_req_t req,
  output prio_pkg::prio_sel_t prio,
  output logic [7:0] rdata,
  output logic rvalid
);
  import prio_pkg::*;

  // The core moves one byte per access and the field map is fixed to it,
  // so a narrower width would leave fields off the end of the register
  if (DATA_W != 8 || TIMER3_BIT >= DATA_W) begin : g_bad_width
    $error("DATA_W must be 8 to hold every priority field");
  end

  logic [DATA_W-1:0] eip_r;
  logic [DATA_W-1:0] eip_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  prio_sel_t prio_r;
  prio_sel_t prio_nxt;
  logic hit;

  // Full address compare; neighbouring registers live at other addresses
  // and must never alias onto this one
  assign hit = (req.addr == EIP_ONE_ADDR);

  // Next register contents; all eight bits are writable, bits 2..0 are kept
  // for the sources served elsewhere so software sees what it wrote
  always_comb begin
    eip_nxt = eip_r;
    if (req.wr && hit) begin
      eip_nxt = req.wdata;
    end
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (req.rd && hit) begin
      rdata_nxt = eip_r; // Read returns value before a same-cycle write
      rvalid_nxt = 1'b1;
    end
    // Decoded from the next value so outputs stay flop-driven and current
    prio_nxt.timer3 = eip_nxt[TIMER3_BIT];
    prio_nxt.comparator_b = eip_nxt[COMP_B_BIT];
    prio_nxt.comparator_a = eip_nxt[COMP_A_BIT];
    prio_nxt.counter_array = eip_nxt[COUNTER_ARRAY_BIT];
    prio_nxt.conversion_done = eip_nxt[CONVERSION_DONE_BIT];
  end

  // State registers, all clear to low priority at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eip_r <= EIP_ONE_RESET;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      prio_r <= '0;
    end else begin
      eip_r <= eip_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      prio_r <= prio_nxt;
    end
  end

  assign prio = prio_r;
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Steps of a register access as the core presents them
  sequence s_write_hit;
    req.wr && hit;
  endsequence

  sequence s_pure_read;
    req.rd && hit && !req.wr;
  endsequence

  sequence s_no_write;
    !(req.wr && hit);
  endsequence

  // Timer 3 level follows the top bit of the written byte
  property p_timer3_write;
    s_write_hit |=>
      prio.timer3 == $past(req.wdata[TIMER3_BIT]);
  endproperty
  a_timer3_write: assert property (p_timer3_write)
    else $error("timer3 priority not taken from bit 7");

  // Second comparator level follows bit 6
  property p_compb_write;
    s_write_hit |=>
      prio.comparator_b == $past(req.wdata[COMP_B_BIT]);
  endproperty
  a_compb_write: assert property (p_compb_write)
    else $error("comparator_b priority not taken from bit 6");

  // First comparator level follows bit 5
  property p_compa_write;
    s_write_hit |=>
      prio.comparator_a == $past(req.wdata[COMP_A_BIT]);
  endproperty
  a_compa_write: assert property (p_compa_write)
    else $error("comparator_a priority not taken from bit 5");

  // Counter array level follows bit 4
  property p_counter_write;
    s_write_hit |=>
      prio.counter_array == $past(req.wdata[COUNTER_ARRAY_BIT]);
  endproperty
  a_counter_write: assert property (p_counter_write)
    else $error("counter_array priority not taken from bit 4");

  // Conversion-done level follows bit 3
  property p_conv_write;
    s_write_hit |=>
      prio.conversion_done == $past(req.wdata[CONVERSION_DONE_BIT]);
  endproperty
  a_conv_write: assert property (p_conv_write)
    else $error("conversion priority not taken from bit 3");

  // Levels only move on a write that hits this register
  property p_prio_hold;
    s_no_write |=>
      $stable(prio);
  endproperty
  a_prio_hold: assert property (p_prio_hold)
    else $error("priority changed without a write");

  // Two clean reads in a row return what the outputs show
  property p_read_back;
    s_pure_read ##1 s_pure_read |=>
      rvalid && rdata[7:3] == prio;
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read value disagrees with priority outputs");

  // A write to another address leaves every level alone
  property p_miss_write;
    req.wr && !hit |=>
      $stable(prio);
  endproperty
  a_miss_write: assert property (p_miss_write)
    else $error("write to other address changed priority");

  // Every read that hits is answered one cycle later
  property p_read_pulse;
    req.rd && hit |=>
      rvalid;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read of the register gave no valid pulse");

  // No answer without a read that hits
  property p_read_quiet;
    !(req.rd && hit) |=>
      !rvalid;
  endproperty
  a_read_quiet: assert property (p_read_quiet)
    else $error("valid pulse without a matching read");

  // A read after a write returns the byte written
  property p_write_read;
    s_write_hit ##1 s_pure_read |=>
      rdata == $past(req.wdata, 2);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("read after write returned a different byte");

  // Read data stands until the next read that hits
  property p_rdata_hold;
    !(req.rd && hit) |=>
      $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  // Low bits are plain storage and read back as written
  property p_low_bits;
    s_write_hit ##1 s_pure_read |=>
      rdata[2:0] == $past(req.wdata[2:0], 2);
  endproperty
  a_low_bits: assert property (p_low_bits)
    else $error("low storage bits not read back");

  // A read beside a write still returns the older byte
  property p_overlap_old;
    s_write_hit ##1 (req.rd && req.wr && hit) |=>
      rdata == $past(req.wdata, 2);
  endproperty
  a_overlap_old: assert property (p_overlap_old)
    else $error("overlapped read did not return the older byte");

  // All sources at high level when every field is written as one
  property p_all_high;
    s_write_hit ##0 (req.wdata[7:3] == 5'h1f) |=>
      prio == 5'h1f;
  endproperty
  a_all_high: assert property (p_all_high)
    else $error("not every source took the high level");

endmodule : ext_interrupt_priority_reg

// File: verif/sfr_core_model.sv
`timescale 1ns/1ns
module sfr_core_model (
  input wire logic clk,
  output prio_pkg::sfr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import prio_pkg::*;
  initial req = '0;
  // Released bus shows inverted address and data, so stale values never match
  task automatic access(input logic [7:0] a, input logic w, input logic r,
      input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clk) req <= '{a, w, r, d};
    @(posedge clk) req <= '{~a, 1'b0, 1'b0, ~d};
    @(negedge clk) q = rdata;
    v = rvalid;
  endtask : access
endmodule : sfr_core_model

// File: verif/ext_interrupt_priority_reg_tb.sv
`timescale 1ns/1ns
module ext_interrupt_priority_reg_tb;
  import prio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sfr_req_t req;
  prio_sel_t prio;
  logic [7:0] rdata, q;
  logic rvalid, v;
  int fails, checks, cyc;
  ext_interrupt_priority_reg i_dut (.clk(clk), .rst_n(rst_n), .req(req), .prio(prio),
    .rdata(rdata), .rvalid(rvalid));
  sfr_core_model i_core (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  initial forever #25 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // Cycle ceiling far above the few dozen cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end
  task automatic test_reset(input string n);
    i_core.access(EIP_ONE_ADDR, 1'b0, 1'b1, 8'h00, q, v);
    chk("reset rdata", EIP_ONE_RESET, q);
    chk("reset rvalid", 8'h01, {7'h0, v});
    chk("reset prio", 8'h00, {3'h0, prio});
    $display("test %s done", n);
  endtask : test_reset
  // One-hot walk shows each field lands on its own priority output
  task automatic test_walk();
    for (int i = 7; i >= 3; i--) begin
      i_core.access(EIP_ONE_ADDR, 1'b1, 1'b0, 8'h01 << i, q, v);
      chk("walk prio", 8'h01 << (i - 3), {3'h0, prio});
      i_core.access(EIP_ONE_ADDR, 1'b0, 1'b1, 8'h00, q, v);
      chk("walk rdata", 8'h01 << i, q);
      chk("walk rvalid", 8'h01, {7'h0, v});
    end
    // Low bits are storage only: read back, every priority output reads low
    i_core.access(EIP_ONE_ADDR, 1'b1, 1'b0, 8'h05, q, v);
    chk("low prio", 8'h00, {3'h0, prio});
    i_core.access(EIP_ONE_ADDR, 1'b0, 1'b1, 8'h00, q, v);
    chk("low rdata", 8'h05, q);
    i_core.access(EIP_ONE_ADDR, 1'b1, 1'b0, 8'h08, q, v);
    $display("test walk done");
  endtask : test_walk
  // Neighbouring address must neither store nor answer
  task automatic test_foreign();
    i_core.access(8'hf7, 1'b1, 1'b1, 8'hff, q, v);
    chk("foreign rvalid", 8'h00, {7'h0, v});
    chk("foreign prio", 8'h01, {3'h0, prio});
    $display("test foreign done");
  endtask : test_foreign
  // Read and write together: old value returned, new value applied
  task automatic test_overlap();
    i_core.access(EIP_ONE_ADDR, 1'b1, 1'b1, 8'hf8, q, v);
    chk("same rdata", 8'h08, q);
    chk("same rvalid", 8'h01, {7'h0, v});
    chk("same prio", 8'h1f, {3'h0, prio});
    $display("test overlap done");
  endtask : test_overlap
  // Reset in mid-run drops every source back to low priority
  task automatic test_mid_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_reset("mid reset");
  endtask : test_mid_reset
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    test_reset("reset");
    test_walk();
    test_foreign();
    test_overlap();
    test_mid_reset();
    end_sim();
  end
endmodule : ext_interrupt_priority_reg_tb
